// ===== inc/vtcm_regs.svh
// Register map, field positions, reset values and frame counts of the monitor
`ifndef VTCM_REGS_SVH
`define VTCM_REGS_SVH

// Register byte offsets
`define VTCM_OFF_CTRL 8'h00
`define VTCM_OFF_DEG 8'h04
`define VTCM_OFF_STATUS 8'h08
`define VTCM_OFF_PM_NEAR 8'h0c
`define VTCM_OFF_PM_FAR 8'h10
`define VTCM_OFF_PM_OFAR 8'h14
`define VTCM_OFF_PM_FLAGS 8'h18
`define VTCM_OFF_EXP_TI 8'h20
`define VTCM_OFF_ACC_TI 8'h30

// Control fields
`define VTCM_CTRL_MON 0
`define VTCM_CTRL_TRACE_MISMATCH_DISABLE 1
`define VTCM_CTRL_SSF_REP 2
`define VTCM_CTRL_RDI_REP 3
`define VTCM_CTRL_ODI_REP 4
`define VTCM_CTRL_INC_REP 5

// Degrade configuration fields
`define VTCM_DEG_WIN_LSB 0
`define VTCM_DEG_THR_LSB 16

// Status fields: defects at the bottom, faults from bit 16
`define VTCM_ST_DEF_LSB 0
`define VTCM_ST_FLT_LSB 16

// Reset values
`define VTCM_CTRL_RST 32'h0000003d
`define VTCM_DEG_RST 32'h01000007

// Frame and multiframe counts
`define VTCM_FRAME_BYTES 8'd140
`define VTCM_N2_IDX 8'd70
`define VTCM_MF_LAST 7'd75
`define VTCM_FAS_END 7'd5
`define VTCM_FAS_NEXT 7'd6
`define VTCM_FAS_PAT 12'hffe
`define VTCM_TI_FIRST 7'd8
`define VTCM_TI_LAST 7'd71
`define VTCM_RDI_FRAME 7'd72
`define VTCM_ODI_FRAME 7'd73
`define VTCM_PERSIST 3'd5
`define VTCM_TI_ACCEPT 2'd3

`endif

// ===== inc/vtcm_pkg.sv
// Types shared by the tandem connection monitor
package vtcm_pkg;

  // Multiframe aligner state
  typedef enum logic [0:0]
  {
    out_of_multiframe = 1'b0,
    in_multiframe_state = 1'b1
  } vtcm_align_t;

  // AXI response codes
  typedef enum logic [1:0]
  {
    vtcm_okay = 2'b00,
    vtcm_slverr = 2'b10
  } vtcm_resp_t;

endpackage

// ===== inc/vtcm_stream_if.sv
// N2 byte stream from the link receiver to the monitor core
`timescale 1ns/10ps
interface vtcm_stream_if;
  logic n2_valid;
  logic [7:0] n2_byte;
  logic bip_err;
  logic ssf;

  modport src (output n2_valid, output n2_byte, output bip_err, output ssf);
  modport snk (input n2_valid, input n2_byte, input bip_err, input ssf);
endinterface

// ===== design/vtcm_link_rx.sv
// Link receiver: pin synchronisers, byte framing and parity check
`timescale 1ns/10ps
module vtcm_link_rx
  import vtcm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Connection point pins
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_fs,
  input wire logic server_fail_in,
  // Byte stream to the core
  vtcm_stream_if.src st
);
  `include "vtcm_regs.svh"

  logic [3:0] s1_r, s2_r, s3_r, stable_r, stable_nxt;
  logic [7:0] sh_r, sh_nxt, idx_r, idx_nxt, byte_v;
  logic [2:0] bit_r, bit_nxt;
  logic [1:0] run_r, run_nxt, prev_r, prev_nxt, bip_v;
  logic ok_r, ok_nxt, framed_r, framed_nxt, edge_v, fs_v;
  logic n2v_r, n2v_nxt, err_r, err_nxt;
  logic [7:0] n2_r, n2_nxt;

  // Each pin counts only once the second and third stages agree
  always_comb
  begin
    stable_nxt = stable_r;
    for (int i = 0; i < 4; i++)
    begin
      if (s2_r[i] == s3_r[i])
        stable_nxt[i] = s3_r[i];
    end
    edge_v = stable_nxt[0] & ~stable_r[0];
    fs_v = stable_r[2];
  end

  // Framing and even parity over bit pairs of each byte
  always_comb
  begin
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    bit_nxt = bit_r;
    run_nxt = run_r;
    prev_nxt = prev_r;
    ok_nxt = ok_r;
    framed_nxt = framed_r;
    n2v_nxt = 1'b0;
    n2_nxt = n2_r;
    err_nxt = err_r;
    byte_v = {sh_r[6:0], stable_r[1]};
    bip_v = {byte_v[7] ^ byte_v[5] ^ byte_v[3] ^ byte_v[1],
             byte_v[6] ^ byte_v[4] ^ byte_v[2] ^ byte_v[0]};
    if (edge_v)
    begin
      sh_nxt = byte_v;
      bit_nxt = bit_r + 3'd1;
      if (fs_v)
      begin
        // A frame start off the byte grid restarts the parity chain
        if (idx_r != 8'd0 || bit_r != 3'd0)
        begin
          run_nxt = 2'b00;
          ok_nxt = 1'b0;
        end
        framed_nxt = 1'b1;
        idx_nxt = 8'd0;
        bit_nxt = 3'd1;
      end
      else if (framed_r && bit_r == 3'd7)
      begin
        if (idx_r == `VTCM_FRAME_BYTES - 8'd1)
        begin
          prev_nxt = run_r ^ bip_v;
          run_nxt = 2'b00;
          ok_nxt = 1'b1;
          idx_nxt = 8'd0;
        end
        else
        begin
          run_nxt = run_r ^ bip_v;
          idx_nxt = idx_r + 8'd1;
        end
        if (idx_r == `VTCM_N2_IDX)
        begin
          n2v_nxt = 1'b1;
          n2_nxt = byte_v;
          err_nxt = ok_r & (byte_v[7:6] != prev_r);
        end
      end
    end
  end

  // Registers; the first stage feeds only the second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      stable_r <= 4'h0;
      sh_r <= 8'h00;
      idx_r <= 8'h00;
      bit_r <= 3'h0;
      run_r <= 2'h0;
      prev_r <= 2'h0;
      ok_r <= 1'b0;
      framed_r <= 1'b0;
      n2v_r <= 1'b0;
      n2_r <= 8'h00;
      err_r <= 1'b0;
    end
    else
    begin
      s1_r <= {server_fail_in, link_fs, link_data, link_clk};
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_r <= stable_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      bit_r <= bit_nxt;
      run_r <= run_nxt;
      prev_r <= prev_nxt;
      ok_r <= ok_nxt;
      framed_r <= framed_nxt;
      n2v_r <= n2v_nxt;
      n2_r <= n2_nxt;
      err_r <= err_nxt;
    end
  end

  assign st.n2_valid = n2v_r;
  assign st.n2_byte = n2_r;
  assign st.bip_err = err_r & n2v_r;
  assign st.ssf = stable_r[3];
endmodule

// ===== design/vtcm_monitor.sv
// Non-intrusive tandem connection monitor with AXI4-Lite registers
// Behaviour
// - Even parity of previous frame checks N2 bits
// - Recover trace, present as accepted trace
// - Only first trace mode is supported
// - Extract incoming alarm bit N2 bit four
// - Extract far-end error bit and remote defect
// - Extract outgoing error bit and outgoing defect
// - Search and check alignment pattern in N2
// - Two errored words lose, one good regains
// - Five zero N2 frames raise no-payload
// - Connection loss follows out-of-multiframe state
// - Trace mismatch set and cleared within second
// - Server fail suppresses trace mismatch
// - Disable bit suppresses trace mismatch
// - Degrade from parity errors, window, threshold
// - Remote defect filtered by persistence
// - Outgoing defect filtered the same way
// - Five frames of bit four flip alarm
// - Trail fail and degrade actions
// - Fault correlation for payload, loss, mismatch
// - Fault correlation for degrade, server fail
// - Remote and outgoing faults, gated, enabled
// - Incoming alarm fault correlation
// - Counts collected per management second tick
`timescale 1ns/10ps
module vtcm_monitor
  import vtcm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Connection point pins
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_fs,
  input wire logic server_fail_in,
  // Management one-second tick, same clock
  input wire logic one_second_tick,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Consequent actions
  output logic trail_fail_out,
  output logic trail_degrade_out
);
  `include "vtcm_regs.svh"

  vtcm_stream_if st ();

  vtcm_link_rx u_rx (
    .clk(clk),
    .reset(reset),
    .link_clk(link_clk),
    .link_data(link_data),
    .link_fs(link_fs),
    .server_fail_in(server_fail_in),
    .st(st)
  );

  // Five-frame style persistence: returns {state, mismatch count}
  function automatic logic [3:0] persist(input logic s, input logic [2:0] c,
                                         input logic v);
    if (v == s)
      persist = {s, 3'd0};
    else if (c == `VTCM_PERSIST - 3'd1)
      persist = {v, 3'd0};
    else
      persist = {s, c + 3'd1};
  endfunction

  // Saturating 16-bit increment; counts freeze rather than wrap
  function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                          input logic en);
    sat_inc = (en && v != 16'hffff) ? v + 16'd1 : v;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  // Mapped word check shared by both channels
  function automatic logic mapped(input logic [7:0] a, input logic wr);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == `VTCM_OFF_CTRL || w == `VTCM_OFF_DEG ||
        w[7:4] == `VTCM_OFF_EXP_TI >> 4)
      mapped = 1'b1;
    else
      mapped = !wr && (w == `VTCM_OFF_STATUS || w == `VTCM_OFF_PM_NEAR ||
        w == `VTCM_OFF_PM_FAR || w == `VTCM_OFF_PM_OFAR ||
        w == `VTCM_OFF_PM_FLAGS || w[7:4] == `VTCM_OFF_ACC_TI >> 4);
  endfunction

  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, degcfg_r, degcfg_nxt;
  logic [31:0] exp_r [0:3];
  logic [31:0] exp_nxt [0:3];
  logic [127:0] exp_ti;
  logic [31:0] status_v;
  logic [15:0] pm_near_r, pm_far_r, pm_ofar_r;
  logic [2:0] pm_ds_r;
  logic [127:0] ti_acc_r;

  // Register file and AXI4-Lite handshakes
  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    degcfg_nxt = degcfg_r;
    exp_nxt = exp_r;
    if (s_axi_awvalid && awready_r)
    begin
      awready_nxt = 1'b0;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      wready_nxt = 1'b0;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    // Write acts once address and data are both held
    if (!awready_r && !wready_r && !bvalid_r)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awaddr_r, 1'b1) ? vtcm_okay : vtcm_slverr;
      if ({awaddr_r[7:2], 2'b00} == `VTCM_OFF_CTRL)
        ctrl_nxt = merge(ctrl_r, wdata_r, wstrb_r);
      else if ({awaddr_r[7:2], 2'b00} == `VTCM_OFF_DEG)
        degcfg_nxt = merge(degcfg_r, wdata_r, wstrb_r);
      else if (awaddr_r[7:4] == `VTCM_OFF_EXP_TI >> 4)
        exp_nxt[awaddr_r[3:2]] = merge(exp_r[awaddr_r[3:2]], wdata_r, wstrb_r);
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(s_axi_araddr, 1'b0) ? vtcm_okay : vtcm_slverr;
      rdata_nxt = 32'h00000000;
      case ({s_axi_araddr[7:2], 2'b00})
        `VTCM_OFF_CTRL: rdata_nxt = ctrl_r;
        `VTCM_OFF_DEG: rdata_nxt = degcfg_r;
        `VTCM_OFF_STATUS: rdata_nxt = status_v;
        `VTCM_OFF_PM_NEAR: rdata_nxt = {16'h0000, pm_near_r};
        `VTCM_OFF_PM_FAR: rdata_nxt = {16'h0000, pm_far_r};
        `VTCM_OFF_PM_OFAR: rdata_nxt = {16'h0000, pm_ofar_r};
        `VTCM_OFF_PM_FLAGS: rdata_nxt = {29'h00000000, pm_ds_r};
        default:
        begin
          if (s_axi_araddr[7:4] == `VTCM_OFF_EXP_TI >> 4)
            rdata_nxt = exp_r[s_axi_araddr[3:2]];
          else if (s_axi_araddr[7:4] == `VTCM_OFF_ACC_TI >> 4)
            rdata_nxt = ti_acc_r[{~s_axi_araddr[3:2], 5'b0} +: 32];
        end
      endcase
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
      ctrl_r <= `VTCM_CTRL_RST;
      degcfg_r <= `VTCM_DEG_RST;
      for (int i = 0; i < 4; i++)
        exp_r[i] <= 32'h00000000;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      degcfg_r <= degcfg_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign exp_ti = {exp_r[0], exp_r[1], exp_r[2], exp_r[3]};

  vtcm_align_t al_r, al_nxt;
  logic [11:0] fas_r, fas_nxt;
  logic [6:0] mf_r, mf_nxt;
  logic ferr_r, ferr_nxt, rdi_bit_r, rdi_bit_nxt, odi_bit_r, odi_bit_nxt;
  logic mfd_r, mfd_nxt;
  logic [127:0] ti_sh_r, ti_sh_nxt, ti_last_r, ti_last_nxt, ti_acc_nxt;
  logic [1:0] ti_cnt_r, ti_cnt_nxt;

  // Multiframe alignment on N2 bits 7 and 8, trace and remote bits
  always_comb
  begin
    al_nxt = al_r;
    fas_nxt = fas_r;
    mf_nxt = mf_r;
    ferr_nxt = ferr_r;
    rdi_bit_nxt = rdi_bit_r;
    odi_bit_nxt = odi_bit_r;
    mfd_nxt = 1'b0;
    ti_sh_nxt = ti_sh_r;
    ti_last_nxt = ti_last_r;
    ti_acc_nxt = ti_acc_r;
    ti_cnt_nxt = ti_cnt_r;
    if (st.n2_valid)
    begin
      fas_nxt = {fas_r[9:0], st.n2_byte[1], st.n2_byte[0]};
      unique case (al_r)
        out_of_multiframe:
        begin
          if (fas_nxt == `VTCM_FAS_PAT)
          begin
            al_nxt = in_multiframe_state;
            mf_nxt = `VTCM_FAS_NEXT;
            ferr_nxt = 1'b0;
          end
        end
        in_multiframe_state:
        begin
          mf_nxt = (mf_r == `VTCM_MF_LAST) ? 7'd0 : mf_r + 7'd1;
          if (mf_r == `VTCM_FAS_END)
          begin
            // Check at the last pattern frame (VTCM_FAS_END); two bad words in a row lose it
            ferr_nxt = (fas_nxt != `VTCM_FAS_PAT);
            if (ferr_nxt && ferr_r)
              al_nxt = out_of_multiframe;
          end
          if (mf_r >= `VTCM_TI_FIRST && mf_r <= `VTCM_TI_LAST)
            ti_sh_nxt = {ti_sh_r[125:0], st.n2_byte[1:0]};
          if (mf_r == `VTCM_RDI_FRAME)
            rdi_bit_nxt = st.n2_byte[0];
          if (mf_r == `VTCM_ODI_FRAME)
            odi_bit_nxt = st.n2_byte[1];
          mfd_nxt = (mf_r == `VTCM_MF_LAST);
        end
      endcase
    end
    // Single trace mode: accept after identical multiframes in a row
    if (mfd_r)
    begin
      ti_last_nxt = ti_sh_r;
      if (ti_sh_r != ti_last_r)
        ti_cnt_nxt = 2'd0;
      else if (ti_cnt_r != `VTCM_TI_ACCEPT - 2'd1)
        ti_cnt_nxt = ti_cnt_r + 2'd1;
      if (ti_sh_r == ti_last_r && ti_cnt_nxt == `VTCM_TI_ACCEPT - 2'd1)
        ti_acc_nxt = ti_sh_r;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      al_r <= out_of_multiframe;
      fas_r <= 12'h000;
      mf_r <= 7'h00;
      ferr_r <= 1'b0;
      rdi_bit_r <= 1'b0;
      odi_bit_r <= 1'b0;
      mfd_r <= 1'b0;
      ti_sh_r <= '0;
      ti_last_r <= '0;
      ti_acc_r <= '0;
      ti_cnt_r <= 2'h0;
    end
    else
    begin
      al_r <= al_nxt;
      fas_r <= fas_nxt;
      mf_r <= mf_nxt;
      ferr_r <= ferr_nxt;
      rdi_bit_r <= rdi_bit_nxt;
      odi_bit_r <= odi_bit_nxt;
      mfd_r <= mfd_nxt;
      ti_sh_r <= ti_sh_nxt;
      ti_last_r <= ti_last_nxt;
      ti_acc_r <= ti_acc_nxt;
      ti_cnt_r <= ti_cnt_nxt;
    end
  end

  logic [3:0] uneq_r, uneq_nxt, inc_r, inc_nxt, rdi_r, rdi_nxt, odi_r, odi_nxt;
  logic ltc_r, ltc_nxt, tim_r, tim_nxt, deg_r, deg_nxt;
  logic [3:0] badc_r, badc_nxt, win_v;
  logic [15:0] secerr_r, secerr_nxt;
  logic bad_v;

  // Defect detection
  always_comb
  begin
    uneq_nxt = uneq_r;
    inc_nxt = inc_r;
    rdi_nxt = rdi_r;
    odi_nxt = odi_r;
    deg_nxt = deg_r;
    badc_nxt = badc_r;
    if (st.n2_valid)
    begin
      uneq_nxt = persist(uneq_r[3], uneq_r[2:0], st.n2_byte == 8'h00);
      inc_nxt = persist(inc_r[3], inc_r[2:0], st.n2_byte[4]);
    end
    if (mfd_r)
    begin
      rdi_nxt = persist(rdi_r[3], rdi_r[2:0], rdi_bit_r);
      odi_nxt = persist(odi_r[3], odi_r[2:0], odi_bit_r);
    end
    ltc_nxt = (al_r == out_of_multiframe);
    // Suppressed under server fail or when disabled
    tim_nxt = (ti_acc_r != exp_ti) && !st.ssf &&
              !ctrl_r[`VTCM_CTRL_TRACE_MISMATCH_DISABLE];
    // Degrade: a second is bad at threshold errors; window of seconds flips
    win_v = degcfg_r[`VTCM_DEG_WIN_LSB +: 4];
    bad_v = secerr_r >= degcfg_r[`VTCM_DEG_THR_LSB +: 16];
    secerr_nxt = sat_inc(secerr_r, st.bip_err);
    if (one_second_tick)
    begin
      secerr_nxt = {15'h0000, st.bip_err};
      if (bad_v == deg_r)
        badc_nxt = 4'd0;
      else if (badc_r + 4'd1 >= win_v)
      begin
        deg_nxt = bad_v;
        badc_nxt = 4'd0;
      end
      else
        badc_nxt = badc_r + 4'd1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      uneq_r <= 4'h0;
      inc_r <= 4'h0;
      rdi_r <= 4'h0;
      odi_r <= 4'h0;
      ltc_r <= 1'b1;
      tim_r <= 1'b0;
      deg_r <= 1'b0;
      badc_r <= 4'h0;
      secerr_r <= 16'h0000;
    end
    else
    begin
      uneq_r <= uneq_nxt;
      inc_r <= inc_nxt;
      rdi_r <= rdi_nxt;
      odi_r <= odi_nxt;
      ltc_r <= ltc_nxt;
      tim_r <= tim_nxt;
      deg_r <= deg_nxt;
      badc_r <= badc_nxt;
      secerr_r <= secerr_nxt;
    end
  end

  logic tsf_r, tsf_nxt, tsd_r, tsd_nxt, mon;
  logic [7:0] flt_r, flt_nxt;
  logic [15:0] an_r, an_nxt, af_r, af_nxt, ao_r, ao_nxt;
  logic [2:0] ads_r, ads_nxt;
  logic [15:0] pm_near_nxt, pm_far_nxt, pm_ofar_nxt;
  logic [2:0] pm_ds_nxt;

  // Consequent actions, fault correlation and per-second counts
  always_comb
  begin
    mon = ctrl_r[`VTCM_CTRL_MON];
    tsf_nxt = st.ssf | uneq_r[3] | tim_r | ltc_r;
    tsd_nxt = deg_r;
    flt_nxt[0] = mon & uneq_r[3];
    flt_nxt[1] = mon & !uneq_r[3] & !st.ssf & ltc_r;
    flt_nxt[2] = mon & !uneq_r[3] & !ltc_r & tim_r;
    flt_nxt[3] = mon & !tim_r & !ltc_r & deg_r;
    flt_nxt[4] = mon & st.ssf & ctrl_r[`VTCM_CTRL_SSF_REP];
    flt_nxt[5] = mon & !uneq_r[3] & !tim_r & !ltc_r & rdi_r[3] &
                 ctrl_r[`VTCM_CTRL_RDI_REP];
    flt_nxt[6] = mon & !uneq_r[3] & !tim_r & !ltc_r & odi_r[3] &
                 ctrl_r[`VTCM_CTRL_ODI_REP];
    flt_nxt[7] = mon & inc_r[3] & !st.ssf & !ltc_r & !tim_r &
                 ctrl_r[`VTCM_CTRL_INC_REP];
    an_nxt = sat_inc(an_r, st.bip_err);
    af_nxt = sat_inc(af_r, st.n2_valid & st.n2_byte[3]);
    ao_nxt = sat_inc(ao_r, st.n2_valid & st.n2_byte[2]);
    ads_nxt = ads_r | {odi_r[3], rdi_r[3], tsf_r};
    pm_near_nxt = pm_near_r;
    pm_far_nxt = pm_far_r;
    pm_ofar_nxt = pm_ofar_r;
    pm_ds_nxt = pm_ds_r;
    // Tick closes the second; same-cycle events open the next one
    if (one_second_tick)
    begin
      pm_near_nxt = an_r;
      pm_far_nxt = af_r;
      pm_ofar_nxt = ao_r;
      pm_ds_nxt = ads_r;
      an_nxt = sat_inc(16'h0000, st.bip_err);
      af_nxt = sat_inc(16'h0000, st.n2_valid & st.n2_byte[3]);
      ao_nxt = sat_inc(16'h0000, st.n2_valid & st.n2_byte[2]);
      ads_nxt = {odi_r[3], rdi_r[3], tsf_r};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tsf_r <= 1'b0;
      tsd_r <= 1'b0;
      flt_r <= 8'h00;
      an_r <= 16'h0000;
      af_r <= 16'h0000;
      ao_r <= 16'h0000;
      ads_r <= 3'h0;
      pm_near_r <= 16'h0000;
      pm_far_r <= 16'h0000;
      pm_ofar_r <= 16'h0000;
      pm_ds_r <= 3'h0;
    end
    else
    begin
      tsf_r <= tsf_nxt;
      tsd_r <= tsd_nxt;
      flt_r <= flt_nxt;
      an_r <= an_nxt;
      af_r <= af_nxt;
      ao_r <= ao_nxt;
      ads_r <= ads_nxt;
      pm_near_r <= pm_near_nxt;
      pm_far_r <= pm_far_nxt;
      pm_ofar_r <= pm_ofar_nxt;
      pm_ds_r <= pm_ds_nxt;
    end
  end

  assign status_v = {8'h00, flt_r, 6'h00, tsd_r, tsf_r, st.ssf, inc_r[3],
                     odi_r[3], rdi_r[3], deg_r, tim_r, ltc_r, uneq_r[3]};
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign trail_fail_out = tsf_r;
  assign trail_degrade_out = tsd_r;
endmodule

// ===== verif/vtcm_link_model.sv
// Far-end source of the stream with tandem connection overhead
`timescale 1ns/10ps
module vtcm_link_model (
  // Control from the bench
  input wire logic start,
  input wire logic [3:0] err_frame,
  // Connection point pins
  output logic link_clk,
  output logic link_data,
  output logic link_fs,
  output logic done
);
  logic [7:0] n2;
  logic [1:0] bip;
  // Six frames; only N2 carries ones, so parity follows N2 alone
  // Bit four stays set throughout so the incoming alarm is raised
  initial
  begin
    {link_clk, link_data, link_fs, done, bip, n2} = '0;
    wait (start);
    for (int f = 0; f < 6; f++)
    begin
      n2 = {bip ^ {1'b0, f == err_frame}, 2'h1, f == 2, f inside {2, 3},
        1'b1, f < 5};
      for (int i = 0; i < 1120; i++)
      begin
        link_fs = (i == 0);
        link_data = (i / 8 == 70) && n2[7 - i % 8];
        #32 link_clk = 1;
        #32 link_clk = 0;
      end
      bip = {n2[7] ^ n2[5] ^ n2[3] ^ n2[1], n2[6] ^ n2[4] ^ n2[2] ^ n2[0]};
    end
    // Clock stands still; released data no longer shows the last bit
    link_data = ~link_data;
    done = 1;
  end
endmodule

// ===== verif/vtcm_monitor_checker.sv
// Port checks of the tandem connection monitor
`timescale 1ns/10ps
module vtcm_monitor_checker (
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic reset,
  input wire logic server_fail_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rready,
  // Outputs
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic trail_fail_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Bus answers come at the promised edge and end at the handshake
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late b");
  a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("second write taken");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("b not released");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("late r");
  a_ar_blocked: assert property (s_axi_arvalid && s_axi_arready
    |=> !s_axi_arready) else $error("second read taken");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("r not released");
  // Fail action; sync delay is short, so eight cycles cover it
  a_fail_on_ssf: assert property (server_fail_in [*8] |-> trail_fail_out)
    else $error("server fail not acted on");
  a_fail_at_start: assert property ($fell(reset) |-> ##[1:2] trail_fail_out)
    else $error("no loss of connection after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_fail_drop: cover property ($fell(trail_fail_out));
endmodule
bind vtcm_monitor vtcm_monitor_checker chk_u (.*);

// ===== verif/test_vtcm_monitor.sv
// Bench for the tandem connection monitor
`timescale 1ns/10ps
`include "vtcm_regs.svh"
module test_vtcm_monitor;
  logic clk, reset, link_clk, link_data, link_fs, server_fail_in, done;
  logic one_second_tick, start, trail_fail_out, trail_degrade_out;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, err_frame;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures, checks;
  vtcm_monitor dut_u (.*);
  vtcm_link_model lm_u (.*);
  // Clock and watchdog; the link run takes about 86k cycles
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #480000;
    failures++;
    tally_and_finish;
  end
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Write with address and data offered together; settle time after
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wready)
        s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk({s_axi_bresp, 32'h0}, {r, 32'h0});
    repeat (8) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk({s_axi_rresp, s_axi_rdata}, {r, d});
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Registers during the link run, then defects, faults and counts
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, server_fail_in, one_second_tick, start} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    err_frame = 4'h3;
    reset = 1;
    repeat (6) @(posedge clk);
    reset <= 0;
    start <= 1;
    rd(`VTCM_OFF_CTRL, `VTCM_CTRL_RST, 2'h0);
    rd(`VTCM_OFF_DEG, `VTCM_DEG_RST, 2'h0);
    wr(`VTCM_OFF_STATUS, 32'h1, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    wait (done);
    rd(`VTCM_OFF_STATUS, 32'h0080_0040, 2'h0);
    wr(`VTCM_OFF_EXP_TI, 32'h1, 2'h0);
    rd(`VTCM_OFF_EXP_TI, 32'h1, 2'h0);
    rd(`VTCM_OFF_STATUS, 32'h0004_0144, 2'h0);
    server_fail_in <= 1;
    repeat (10) @(posedge clk);
    rd(`VTCM_OFF_STATUS, 32'h0010_01c0, 2'h0);
    server_fail_in <= 0;
    wr(`VTCM_OFF_CTRL, 32'h3f, 2'h0);
    rd(`VTCM_OFF_STATUS, 32'h0080_0040, 2'h0);
    wr(`VTCM_OFF_CTRL, 32'h3c, 2'h0);
    rd(`VTCM_OFF_STATUS, 32'h0000_0144, 2'h0);
    one_second_tick <= 1;
    @(posedge clk);
    one_second_tick <= 0;
    rd(`VTCM_OFF_PM_NEAR, 32'h1, 2'h0);
    rd(`VTCM_OFF_PM_FAR, 32'h1, 2'h0);
    rd(`VTCM_OFF_PM_OFAR, 32'h2, 2'h0);
    rd(`VTCM_OFF_PM_FLAGS, 32'h1, 2'h0);
    // Zero threshold and a one-second window: the next tick degrades
    wr(`VTCM_OFF_DEG, 32'h0000_0001, 2'h0);
    one_second_tick <= 1;
    @(posedge clk);
    one_second_tick <= 0;
    repeat (2) @(posedge clk);
    chk({33'h0, trail_degrade_out}, 34'h1);
    tally_and_finish;
  end
endmodule
